// >>> rtl/sre_route_edge.sv
// management interrupt routing, either-edge gpio status and standby por status
// Behaviour
// R1: enable bits 0..3 gate mouse, keyboard, ir and b sources onto group interrupt
// R2: bit 4 routes keyboard-controller port bit onto group interrupt
// R3: bit 5 enables consumer ir, using its wake status as source
// R4: bit 6 gates group interrupt into wake logic
// R5: bit 7 enables group interrupt onto pin or frame slot, else floats
// R6: mux control bit 7 picks pin or serial irq frame
// R7: four gpio pins raise interrupts on both edges
// R8: either-edge works only when that pin's group interrupt is enabled
// R9: in either-edge mode polarity only inverts the reported data bit
// R10: interrupt when status set and enabled; status latches regardless
// R11: status bits 0..3 set by edges on pins 11, 12, 53, 54
// R12: writing one clears an edge status bit; zero does nothing
// R13: bit 4 set by standby por, write-one clears, sci on power on
// R14: status bits 5..7 read zero
// R15: both registers reset to zero
// R16: group interrupt combines all enabled sources and other events
// R17: ir status set by receive transition, cleared by reading it
// R18: pins synchronised, compared to previous sample, difference sets status
// R19: group output active low while any enabled status stands
`timescale 1ns/100ps
module sre_route_edge
  import sre_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire sre_bus_t hostBus,
  output logic [REG_W-1:0] readData,
  input wire sre_src_t sources,
  input wire logic irRx,
  input wire logic otherMgmtEvents,
  input wire logic [NUM_EDGE-1:0] gpioPin,
  input wire logic [NUM_EDGE-1:0] eitherEdgeSel,
  input wire logic [NUM_EDGE-1:0] edgeIrqEn,
  input wire logic [NUM_EDGE-1:0] gpioPolarity,
  input wire logic gpioGroupIrqOneEn,
  input wire logic gpioGroupIrqTwoEn,
  input wire logic irqMuxSelFrame,
  input wire logic standbyPorEvent,
  input wire logic systemPowerOn_n,
  output logic groupMgmtIrq_n,
  output logic groupMgmtIrqOe,
  output logic serialIrqSlot2,
  output logic groupToWake,
  output logic [NUM_EDGE-1:0] gpioDataBit,
  output logic [NUM_EDGE-1:0] eitherEdgeIrq,
  output logic standbySci
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by second
  logic [NUM_EDGE-1:0] pinSync;
  logic [NUM_EDGE-1:0] pinPrev;
  logic irSync;
  logic irPrev;
  logic porSync;
  logic porPrev;
  logic pwrSync;
  logic pwrPrev;

  sre_sync_edge
  #(
    .WIDTH(NUM_EDGE),
    .IDLE('0)
  )
  pinSyncer
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn(gpioPin),
    .syncOut(pinSync),
    .prevOut(pinPrev)
  ); // R18

  sre_sync_edge
  #(
    .WIDTH(1),
    .IDLE('0)
  )
  irSyncer
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn(irRx),
    .syncOut(irSync),
    .prevOut(irPrev)
  ); // R17

  sre_sync_edge
  #(
    .WIDTH(1),
    .IDLE('0)
  )
  porSyncer
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn(standbyPorEvent),
    .syncOut(porSync),
    .prevOut(porPrev)
  ); // R13

  // power-on request idles high, so its stages rest high: no false fall after reset
  sre_sync_edge
  #(
    .WIDTH(1),
    .IDLE(1'b1)
  )
  pwrSyncer
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn(systemPowerOn_n),
    .syncOut(pwrSync),
    .prevOut(pwrPrev)
  ); // R13

  logic [NUM_EDGE-1:0] pinEdge;
  logic irEdge;
  logic porRise;
  logic powerOnFall;
  assign pinEdge = pinSync ^ pinPrev; // R18 R7
  assign irEdge = irSync ^ irPrev;
  assign porRise = porSync & ~porPrev;
  assign powerOnFall = ~pwrSync & pwrPrev;

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [REG_W-1:0] enableTwo;
  logic [REG_W-1:0] miscStatus;
  logic irTransitionStatus;
  logic bStatus;
  logic porCaused;
  logic [REG_W-1:0] next_enableTwo;
  logic [REG_W-1:0] next_miscStatus;
  logic next_irTransitionStatus;
  logic next_bStatus;
  logic next_porCaused;
  logic [REG_W-1:0] next_readData;
  logic wrEnable;
  logic wrStatus;
  logic rdStsTwo;

  assign wrEnable = hostBus.wr && hostBus.addr == OFS_ENABLE_TWO;
  assign wrStatus = hostBus.wr && hostBus.addr == OFS_MISC_STATUS;
  assign rdStsTwo = hostBus.rd && hostBus.addr == OFS_SMI_STATUS_TWO;

  always_comb
  begin
    next_enableTwo = enableTwo;
    if (wrEnable)
      next_enableTwo = hostBus.wdata;
    next_miscStatus = miscStatus;
    // set wins over clear
    if (wrStatus)
      next_miscStatus = miscStatus & ~hostBus.wdata; // R12
    next_miscStatus[NUM_EDGE-1:0] = next_miscStatus[NUM_EDGE-1:0] | pinEdge; // R11 R10
    if (porRise)
      next_miscStatus[BIT_STANDBY_POR] = 1'b1; // R13
    next_miscStatus = next_miscStatus & MISC_USED_MASK; // R14
    // read clears, but a transition in the same cycle survives
    next_irTransitionStatus = (irTransitionStatus & ~rdStsTwo) | irEdge; // R17
    next_bStatus = (bStatus & ~rdStsTwo) | sources.bSource;
    next_porCaused = porCaused;
    if (porRise)
      next_porCaused = 1'b1;
    else if (powerOnFall)
      next_porCaused = 1'b0;
    next_readData = readData;
    if (hostBus.rd)
    begin
      case (hostBus.addr)
        OFS_ENABLE_TWO: next_readData = enableTwo;
        OFS_MISC_STATUS: next_readData = miscStatus & MISC_USED_MASK; // R14
        OFS_SMI_STATUS_TWO: next_readData = {3'h0, sources.kbcPortBit, bStatus,
          irTransitionStatus, sources.keyboard, sources.mouse}; // R17
        default: next_readData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      enableTwo <= RESET_ENABLE_TWO; // R15
      miscStatus <= RESET_MISC_STATUS; // R15
      irTransitionStatus <= 1'b0;
      bStatus <= 1'b0;
      porCaused <= 1'b0;
      readData <= 8'h00;
    end
    else
    begin
      enableTwo <= next_enableTwo;
      miscStatus <= next_miscStatus;
      irTransitionStatus <= next_irTransitionStatus;
      bStatus <= next_bStatus;
      porCaused <= next_porCaused;
      readData <= next_readData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // either-edge interrupts and group interrupt
  logic [NUM_EDGE-1:0] groupOk;
  logic groupActive;
  logic [NUM_EDGE-1:0] next_eitherEdgeIrq;
  logic [NUM_EDGE-1:0] next_gpioDataBit;
  logic next_groupMgmtIrq_n;
  logic next_groupMgmtIrqOe;
  logic next_serialIrqSlot2;
  logic next_groupToWake;
  logic next_standbySci;

  // pins 11 and 12 sit in group one, 53 and 54 in group two
  assign groupOk = {gpioGroupIrqTwoEn, gpioGroupIrqTwoEn, gpioGroupIrqOneEn,
    gpioGroupIrqOneEn}; // R8

  always_comb
  begin
    next_eitherEdgeIrq = miscStatus[NUM_EDGE-1:0] & edgeIrqEn & eitherEdgeSel & groupOk; // R10 R8
    // polarity still inverts the reported data bit only
    next_gpioDataBit = pinSync ^ gpioPolarity; // R9
    groupActive = (enableTwo[BIT_MOUSE] & sources.mouse)
      | (enableTwo[BIT_KEYBOARD] & sources.keyboard)
      | (enableTwo[BIT_IR] & irTransitionStatus)
      | (enableTwo[BIT_B] & bStatus) // R1
      | (enableTwo[BIT_KBC_ROUTE] & sources.kbcPortBit) // R2
      | (enableTwo[BIT_CIR] & sources.consumerIrWake) // R3
      | otherMgmtEvents; // R16
    next_groupToWake = enableTwo[BIT_TO_WAKE] & groupActive; // R4
    // pin driven only when enabled and not routed to the frame
    next_groupMgmtIrqOe = enableTwo[BIT_OUTPUT] & ~irqMuxSelFrame; // R5 R6
    next_groupMgmtIrq_n = ~(groupActive & enableTwo[BIT_OUTPUT]); // R19
    next_serialIrqSlot2 = enableTwo[BIT_OUTPUT] & irqMuxSelFrame & groupActive; // R6
    next_standbySci = porCaused & powerOnFall; // R13
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      eitherEdgeIrq <= '0;
      gpioDataBit <= '0;
      groupMgmtIrq_n <= 1'b1;
      groupMgmtIrqOe <= 1'b0;
      serialIrqSlot2 <= 1'b0;
      groupToWake <= 1'b0;
      standbySci <= 1'b0;
    end
    else
    begin
      eitherEdgeIrq <= next_eitherEdgeIrq;
      gpioDataBit <= next_gpioDataBit;
      groupMgmtIrq_n <= next_groupMgmtIrq_n;
      groupMgmtIrqOe <= next_groupMgmtIrqOe;
      serialIrqSlot2 <= next_serialIrqSlot2;
      groupToWake <= next_groupToWake;
      standbySci <= next_standbySci;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser plus a previous-sample stage for edge compare
module sre_sync_edge
  import sre_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut,
  output logic [WIDTH-1:0] prevOut
);

  // meta may go metastable, so only the second stage reads it
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_syncOut;
  logic [WIDTH-1:0] next_prevOut;

  always_comb
  begin
    next_meta = asyncIn;
    next_syncOut = meta;
    next_prevOut = syncOut;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      meta <= IDLE;
      syncOut <= IDLE;
      prevOut <= IDLE;
    end
    else
    begin
      meta <= next_meta;
      syncOut <= next_syncOut;
      prevOut <= next_prevOut;
    end
  end

endmodule

// >>> rtl/sre_pkg.sv
// package for the management interrupt routing and either-edge status block
package sre_pkg;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  // register offsets within the power block
  localparam logic [7:0] OFS_ENABLE_TWO = 8'h15;
  localparam logic [7:0] OFS_MISC_STATUS = 8'h16;
  localparam logic [7:0] OFS_SMI_STATUS_TWO = 8'h13;
  localparam logic [7:0] RESET_ENABLE_TWO = 8'h00;
  localparam logic [7:0] RESET_MISC_STATUS = 8'h00;
  // enable register two fields
  localparam int BIT_MOUSE = 0;
  localparam int BIT_KEYBOARD = 1;
  localparam int BIT_IR = 2;
  localparam int BIT_B = 3;
  localparam int BIT_KBC_ROUTE = 4;
  localparam int BIT_CIR = 5;
  localparam int BIT_TO_WAKE = 6;
  localparam int BIT_OUTPUT = 7;
  // misc status fields
  localparam int NUM_EDGE = 4;
  localparam int BIT_STANDBY_POR = 4;
  localparam logic [7:0] MISC_USED_MASK = 8'h1f;
  // smi status two fields read-clear
  localparam logic [7:0] STS_TWO_READ_CLEAR = 8'h0c;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
  } sre_bus_t;

  typedef struct packed {
    logic mouse;
    logic keyboard;
    logic kbcPortBit;
    logic consumerIrWake;
    logic bSource;
  } sre_src_t;
endpackage

// >>> tb/sre_host_model.sv
// host side model of the group management interrupt receiver
`timescale 1ns/100ps
module sre_host_model
(
  input wire logic groupMgmtIrq_n,
  input wire logic groupMgmtIrqOe,
  input wire logic serialIrqSlot2,
  output logic smiSeen
);
  // a released pin rests high through the board pull-up, so it never reads as a request
  assign smiSeen = (groupMgmtIrqOe ? !groupMgmtIrq_n : 1'b0) || serialIrqSlot2;
endmodule

// >>> tb/sre_route_edge_chk.sv
// assertion checker for the routing and either-edge status block
`timescale 1ns/100ps
module sre_route_edge_chk
  import sre_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire sre_bus_t hostBus,
  input wire logic [REG_W-1:0] readData,
  input wire logic irqMuxSelFrame,
  input wire logic gpioGroupIrqOneEn,
  input wire logic [NUM_EDGE-1:0] gpioPin,
  input wire logic [NUM_EDGE-1:0] eitherEdgeSel,
  input wire logic [NUM_EDGE-1:0] edgeIrqEn,
  input wire logic groupMgmtIrq_n,
  input wire logic groupMgmtIrqOe,
  input wire logic serialIrqSlot2,
  input wire logic [NUM_EDGE-1:0] eitherEdgeIrq,
  input wire logic standbySci
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // enabled edge on pin 0; sync, status and irq stages take four edges
  sequence pinEdge;
    $changed(gpioPin[0]) && eitherEdgeSel[0] && edgeIrqEn[0] && gpioGroupIrqOneEn;
  endsequence
  chk_one_route: assert property (!(serialIrqSlot2 && groupMgmtIrqOe))
    else $error("pin and frame slot both active");
  chk_oe_pin_sel: assert property (groupMgmtIrqOe |-> !$past(irqMuxSelFrame))
    else $error("pin enabled while frame selected");
  chk_frame_sel: assert property (serialIrqSlot2 |-> $past(irqMuxSelFrame))
    else $error("frame slot while pin selected");
  chk_slot_low: assert property (serialIrqSlot2 |-> !groupMgmtIrq_n)
    else $error("frame slot without group request");
  chk_irq_group: assert property (|eitherEdgeIrq[1:0] |-> $past(gpioGroupIrqOneEn))
    else $error("edge irq without group enable");
  chk_irq_enabled: assert property (eitherEdgeIrq[0] |-> $past(edgeIrqEn[0]))
    else $error("edge irq while disabled");
  chk_edge_irq: assert property (pinEdge |-> ##[1:5] eitherEdgeIrq[0])
    else $error("pin edge raised no irq");
  chk_sci_pulse: assert property (standbySci |=> !standbySci)
    else $error("sci longer than one cycle");
  chk_reserved_zero: assert property (hostBus.rd && hostBus.addr == OFS_MISC_STATUS
    |=> readData[7:5] == 3'h0)
    else $error("reserved status bits set");
endmodule
bind sre_route_edge sre_route_edge_chk chk (.ref_clk(ref_clk), .reset(reset),
  .hostBus(hostBus), .readData(readData), .irqMuxSelFrame(irqMuxSelFrame),
  .gpioGroupIrqOneEn(gpioGroupIrqOneEn), .gpioPin(gpioPin), .eitherEdgeSel(eitherEdgeSel),
  .edgeIrqEn(edgeIrqEn), .groupMgmtIrq_n(groupMgmtIrq_n), .groupMgmtIrqOe(groupMgmtIrqOe),
  .serialIrqSlot2(serialIrqSlot2), .eitherEdgeIrq(eitherEdgeIrq), .standbySci(standbySci));

// >>> tb/tb_top.sv
// self-checking bench for the routing and either-edge status block
`timescale 1ns/100ps
module tb_top
  import sre_pkg::*;
;
  logic ref_clk, reset, irRx, otherMgmtEvents, irqMuxSelFrame, grpOne, grpTwo;
  logic porEvt, powerOn_n, irqN, irqOe, slot2, toWake, standbySci, smiSeen;
  logic [3:0] gpioPin, eeSel, irqEn, pol, dataBit, eeIrq, e, ex;
  logic [7:0] readData, rv, en;
  sre_bus_t hostBus;
  sre_src_t sources;
  int err_count, n_checks, seed, seen;
  sre_route_edge dut (.ref_clk(ref_clk), .reset(reset), .hostBus(hostBus),
    .readData(readData), .sources(sources), .irRx(irRx), .otherMgmtEvents(otherMgmtEvents),
    .gpioPin(gpioPin), .eitherEdgeSel(eeSel), .edgeIrqEn(irqEn), .gpioPolarity(pol),
    .gpioGroupIrqOneEn(grpOne), .gpioGroupIrqTwoEn(grpTwo), .irqMuxSelFrame(irqMuxSelFrame),
    .standbyPorEvent(porEvt), .systemPowerOn_n(powerOn_n), .groupMgmtIrq_n(irqN),
    .groupMgmtIrqOe(irqOe), .serialIrqSlot2(slot2), .groupToWake(toWake),
    .gpioDataBit(dataBit), .eitherEdgeIrq(eeIrq), .standbySci(standbySci));
  sre_host_model host (.groupMgmtIrq_n(irqN), .groupMgmtIrqOe(irqOe),
    .serialIrqSlot2(slot2), .smiSeen(smiSeen));
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    n_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic bus(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    hostBus = '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge ref_clk) #1;
    hostBus = '0;
    rv = readData;
  endtask
  // expected group pin level; ir and b statuses are clear during the random sweep
  function automatic logic grpN(input logic [7:0] n, input sre_src_t s);
    return !(n[7] && ((n[BIT_MOUSE] && s.mouse) || (n[BIT_KEYBOARD] && s.keyboard)
      || (n[BIT_KBC_ROUTE] && s.kbcPortBit) || (n[BIT_CIR] && s.consumerIrWake)));
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    #200000;
    err_count++;
    test_done;
  end
  initial
  begin
    seed = 32'hca3e;
    {reset, irRx, otherMgmtEvents, irqMuxSelFrame, grpOne, grpTwo, porEvt} = 7'h40;
    {powerOn_n, gpioPin, eeSel, irqEn, pol, hostBus, sources} = '0;
    powerOn_n = 1;
    repeat (2) @(posedge ref_clk);
    #1 reset = 0;
    bus(1, OFS_ENABLE_TWO, 8'h00);
    chk("enable reset", 8'h00, rv);
    bus(1, OFS_MISC_STATUS, 8'h00);
    chk("status reset", 8'h00, rv);
    bus(1, 8'h20, 8'h00);
    chk("unmapped read", 8'h00, rv);
    // bSource held low: its pulse would latch a status the model does not track
    repeat (16)
    begin
      en = 8'($random(seed));
      sources = 5'($random(seed)) & 5'h1e;
      irqMuxSelFrame = 1'($random(seed));
      bus(0, OFS_ENABLE_TWO, en);
      bus(1, OFS_ENABLE_TWO, 8'h00);
      chk("enable two", en, rv);
      chk("group pin", 8'(grpN(en, sources)), 8'(irqN));
      chk("pin enable", 8'(en[7] && !irqMuxSelFrame), 8'(irqOe));
      chk("frame slot", 8'(!grpN(en, sources) && irqMuxSelFrame), 8'(slot2));
      chk("to wake", 8'(en[6] && !grpN(en | 8'h80, sources)), 8'(toWake));
      chk("host sees", 8'(!grpN(en, sources)), 8'(smiSeen));
    end
    // ir transition and b pulse latch status, group pin follows, status-two read clears
    sources = '0;
    bus(0, OFS_ENABLE_TWO, 8'h8c);
    irRx = 1;
    sources.bSource = 1;
    @(posedge ref_clk) #1;
    sources.bSource = 0;
    repeat (4) @(posedge ref_clk);
    #1 chk("ir b group", 8'h00, 8'(irqN));
    bus(1, OFS_SMI_STATUS_TWO, 8'h00);
    chk("status two", 8'h0c, rv);
    repeat (2) @(posedge ref_clk);
    #1 chk("read clears", 8'h01, 8'(irqN));
    // other events reach wake without bit 7, the pin only with it
    otherMgmtEvents = 1;
    bus(0, OFS_ENABLE_TWO, 8'h40);
    @(posedge ref_clk) #1;
    chk("other wake", 8'h01, 8'(toWake));
    chk("other pin off", 8'h01, 8'(irqN));
    bus(0, OFS_ENABLE_TWO, 8'h80);
    @(posedge ref_clk) #1;
    chk("other pin", 8'h00, 8'(irqN));
    chk("wake off", 8'h00, 8'(toWake));
    otherMgmtEvents = 0;
    // first pass is a fixed corner: every pin moves, group two held off
    for (int i = 0; i < 9; i++)
    begin
      {e, eeSel, irqEn, pol, grpOne, grpTwo} = (i == 0) ? 18'h3fffe : 18'($random(seed));
      bus(0, OFS_MISC_STATUS, 8'h0f);
      gpioPin = gpioPin ^ e;
      repeat (6) @(posedge ref_clk);
      ex = e & eeSel & irqEn & {grpTwo, grpTwo, grpOne, grpOne};
      #1 chk("edge irq", 8'(ex), 8'(eeIrq));
      chk("data bit", 8'(gpioPin ^ pol), 8'(dataBit));
      bus(0, OFS_MISC_STATUS, 8'h00);
      bus(1, OFS_MISC_STATUS, 8'h00);
      chk("edge status", 8'(e), rv);
    end
    porEvt = 1;
    repeat (4) @(posedge ref_clk);
    bus(1, OFS_MISC_STATUS, 8'h00);
    chk("por status", 8'h1f & {4'h0, gpioPin ^ gpioPin} | 8'h10 | 8'(e), rv);
    powerOn_n = 0;
    seen = 0;
    repeat (8)
    begin
      @(posedge ref_clk) #1;
      seen += standbySci;
    end
    chk("sci pulses", 8'h01, 8'(seen));
    bus(0, OFS_MISC_STATUS, 8'hff);
    bus(1, OFS_MISC_STATUS, 8'h00);
    chk("cleared status", 8'h00, rv);
    test_done;
  end
endmodule
